// ==== hw/throttle_position_controller.sv ====
// throttle plate position loop: AXI4-Lite registers, angle scaling,
// filter, lead/lag setpoint, split-gain PID, compensations, PWM ticks
// assumes: sensor and battery samples synchronous to CLOCK
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`include "throttle_regs.svh"
module throttle_position_controller #(
   parameter int LOOP_COUNT   = `CLK_HZ / `LOOP_HZ,
   parameter int PERIOD_TICKS = `TICK_HZ / `PWM_HZ,
   parameter int PW           = $clog2(PERIOD_TICKS + 1),
   parameter int AW           = `AXI_AW
) (
   input  wire logic                CLOCK,
   input  wire logic                RESET,
   input  wire logic [AW-1:0]       AWADDR,
   input  wire logic                AWVALID,
   output logic                     AWREADY,
   input  wire logic [31:0]         WDATA,
   input  wire logic [3:0]          WSTRB,
   input  wire logic                WVALID,
   output logic                     WREADY,
   output logic [1:0]               BRESP,
   output logic                     BVALID,
   input  wire logic                BREADY,
   input  wire logic [AW-1:0]       ARADDR,
   input  wire logic                ARVALID,
   output logic                     ARREADY,
   output logic [31:0]              RDATA,
   output logic [1:0]               RRESP,
   output logic                     RVALID,
   input  wire logic                RREADY,
   input  wire logic [15:0]         SENSOR_RAW,
   input  wire throttle_pkg::q16_t  BATTERY_VOLTS,
   output logic [PW-1:0]            PWM_PERIOD,
   output logic signed [PW:0]       PWM_WIDTH,
   output logic                     PWM_UPDATE
);
   import throttle_pkg::*;
   localparam int LCW = $clog2(LOOP_COUNT);
   localparam logic [15:0] WOT_Q = 16'(`WOT_ANGLE_DEG << `FRAC_BITS);
   localparam logic [`DIV_W-1:0] PER_W = `DIV_W'(PERIOD_TICKS);

   function automatic logic [4:0] addr_idx(input logic [AW-1:0] a);
      return 5'(a >> 2);
   endfunction

   logic [15:0]       cfg_r [0:`NUM_CFG-1];
   logic              aw_held_r, w_held_r, wr_fire, wr_ok;
   logic [4:0]        aw_idx_r, ar_idx;
   logic [15:0]       w_data_r;
   logic [1:0]        w_strb_r;
   logic [31:0]       rd_word;
   logic              run, batt_en, filt_en;
   logic [LCW-1:0]    loop_cnt_r;
   logic              loop_tick;
   seq_e              st_r;
   logic              div_start_r, div_done;
   logic [`DIV_W-1:0] div_num, div_quot;
   logic [15:0]       div_den, sens_r, batt_r, angle_clip, mag;
   q16_t              raw_angle_r, lp_y, theta_r;
   q16_t              lag_r, sp_prev_r, integ_r, err_prev_r, ulh_r;
   q16_t              sp_ff_r, u_pid_r, ufc_r, u_r;
   q16_t              sp, lagged, sp_ff, err, p_term, integ_nxt;
   q16_t              d_term, upid, ulh_nxt, ufc, kp, ti, td;
   logic              above, above_r, near_lh;
   logic [PW-1:0]     w_mag;

   assign run     = cfg_r[`IX_CTRL][`CTRL_RUN];
   assign batt_en = cfg_r[`IX_CTRL][`CTRL_BATT];
   assign filt_en = cfg_r[`IX_CTRL][`CTRL_FILT];

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   assign AWREADY = !aw_held_r && !BVALID;
   assign WREADY  = !w_held_r && !BVALID;
   assign ARREADY = !RVALID;
   assign wr_fire = aw_held_r && w_held_r && !BVALID;
   assign wr_ok   = aw_idx_r < `NUM_CFG;
   assign ar_idx  = addr_idx(ARADDR);

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         aw_held_r <= 1'b0;
         aw_idx_r  <= 5'h00;
      end else if (AWVALID && AWREADY) begin
         aw_held_r <= 1'b1;
         aw_idx_r  <= addr_idx(AWADDR);
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         w_held_r <= 1'b0;
         w_data_r <= 16'h0000;
         w_strb_r <= 2'h0;
      end else if (WVALID && WREADY) begin
         w_held_r <= 1'b1;
         w_data_r <= WDATA[15:0];
         w_strb_r <= WSTRB[1:0];
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         BVALID <= 1'b0;
         BRESP  <= `RESP_OKAY;
      end else if (wr_fire) begin
         BVALID <= 1'b1;
         BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // byte lanes above 1 land on no storage
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         for (int i = 0; i < `NUM_CFG; i++) begin
            cfg_r[i] <= 16'h0000;
         end
         cfg_r[`IX_SENS_MAX] <= `RST_SENS_MAX;
         cfg_r[`IX_BATT_NOM] <= `RST_BATT_NOM;
      end else if (wr_fire && wr_ok) begin
         if (w_strb_r[0]) begin
            cfg_r[aw_idx_r][7:0] <= w_data_r[7:0];
         end
         if (w_strb_r[1]) begin
            cfg_r[aw_idx_r][15:8] <= w_data_r[15:8];
         end
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (ar_idx < `NUM_CFG) begin
         rd_word = {16'h0000, cfg_r[ar_idx]};
      end else begin
         unique case (ar_idx)
            `IX_STATUS:  rd_word = {30'h0, above_r, st_r != ST_IDLE};
            `IX_ANGLE:   rd_word = {16'h0000, theta_r};
            `IX_SP_FF:   rd_word = {16'h0000, sp_ff_r};
            `IX_U_PID:   rd_word = {16'h0000, u_pid_r};
            `IX_U_TOTAL: rd_word = {16'h0000, u_r};
            `IX_WIDTH:   rd_word = 32'({1'b0, PWM_WIDTH});
            default:     rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0000_0000;
         RRESP  <= `RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RDATA  <= rd_word;
         RRESP  <= (ar_idx <= `IX_LAST) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // ************************************************************
   // loop timer and sequencer
   // ************************************************************
   assign loop_tick = loop_cnt_r == LCW'(LOOP_COUNT - 1);

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         loop_cnt_r <= '0;
      end else begin
         loop_cnt_r <= loop_tick ? '0 : loop_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         st_r <= ST_IDLE;
      end else begin
         unique case (st_r)
            ST_IDLE:    if (loop_tick && run) st_r <= ST_ANGLE;
            ST_ANGLE:   if (div_done) st_r <= ST_FILTER;
            ST_FILTER:  st_r <= ST_CONTROL;
            ST_CONTROL: st_r <= ST_MOTOR;
            ST_MOTOR:   if (div_done) st_r <= ST_OUTPUT;
            ST_OUTPUT:  st_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         div_start_r <= 1'b0;
         sens_r      <= 16'h0000;
         batt_r      <= 16'h0000;
      end else begin
         div_start_r <= (st_r == ST_IDLE && loop_tick && run)
                        || st_r == ST_CONTROL;
         if (st_r == ST_IDLE && loop_tick) begin
            sens_r <= SENSOR_RAW;
            batt_r <= BATTERY_VOLTS;
         end
      end
   end

   // ************************************************************
   // shared divider: angle scaling, then duty scaling
   // ************************************************************
   always_comb begin
      mag = abs16(u_r);
      if (st_r == ST_MOTOR) begin
         div_num = `DIV_W'(mag) * PER_W;
         div_den = batt_en ? batt_r : cfg_r[`IX_BATT_NOM];
      end else begin
         div_num = '0;
         if (sens_r > cfg_r[`IX_SENS_MIN]) begin
            div_num = `DIV_W'(sens_r - cfg_r[`IX_SENS_MIN])
                      * `DIV_W'(WOT_Q);
         end
         div_den = 16'h0000;
         if (cfg_r[`IX_SENS_MAX] > cfg_r[`IX_SENS_MIN]) begin
            div_den = cfg_r[`IX_SENS_MAX] - cfg_r[`IX_SENS_MIN];
         end
      end
      angle_clip = (div_quot > `DIV_W'(WOT_Q)) ? WOT_Q : div_quot[15:0];
      w_mag = (div_quot > PER_W) ? PW'(PERIOD_TICKS) : div_quot[PW-1:0];
   end

   ctl_divider #(.W(`DIV_W), .DW(16)) u_div (
      .clk   (CLOCK),
      .rst   (RESET),
      .start (div_start_r),
      .num   (div_num),
      .den   (div_den),
      .done  (div_done),
      .quot  (div_quot)
   );

   ctl_lowpass2 u_lp (
      .clk    (CLOCK),
      .rst    (RESET),
      .sample (st_r == ST_ANGLE && div_done),
      .x      (angle_clip),
      .y      (lp_y)
   );

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         raw_angle_r <= 16'sh0000;
         theta_r     <= 16'sh0000;
      end else if (st_r == ST_ANGLE && div_done) begin
         raw_angle_r <= angle_clip;
      end else if (st_r == ST_FILTER) begin
         theta_r <= filt_en ? lp_y : raw_angle_r;
      end
   end

   // ************************************************************
   // setpoint shaping, PID and compensation terms
   // ************************************************************
   always_comb begin
      sp      = cfg_r[`IX_SETPOINT];
      above   = theta_r > q16_t'(cfg_r[`IX_LH_ANGLE]);
      kp      = above ? cfg_r[`IX_KP_POS] : cfg_r[`IX_KP_NEG];
      ti      = above ? cfg_r[`IX_TI_POS] : cfg_r[`IX_TI_NEG];
      td      = above ? cfg_r[`IX_TD_POS] : cfg_r[`IX_TD_NEG];
      // zero lag/lead factors pass the setpoint straight through
      lagged  = add16(sp, mulq(sub16(lag_r, sp), cfg_r[`IX_LAG]));
      sp_ff   = add16(lagged,
                      mulq(sub16(sp, sp_prev_r), cfg_r[`IX_LEAD]));
      err     = sub16(sp_ff, theta_r);
      p_term  = mulq(kp, err);
      integ_nxt = (ti == 0) ? 16'sh0000
                            : add16(integ_r, mulq(ti, err));
      d_term  = (td == 0) ? 16'sh0000
                          : mulq(td, sub16(err, err_prev_r));
      upid    = add16(add16(p_term, integ_nxt), d_term);
      near_lh = abs16(sub16(sp, cfg_r[`IX_LH_ANGLE]))
                <= q16_t'(cfg_r[`IX_LH_WINDOW]);
      ulh_nxt = ulh_r;
      if (near_lh) begin
         ulh_nxt = (err > 0) ? q16_t'(cfg_r[`IX_LH_STEP])
                  : sub16(16'sh0000, cfg_r[`IX_LH_STEP]);
      end
      ufc = 16'sh0000;
      if (!near_lh && err > 0) begin
         ufc = cfg_r[`IX_ST_STEP];
      end else if (!near_lh && err < 0) begin
         ufc = sub16(16'sh0000, cfg_r[`IX_ST_STEP]);
      end
   end

   // only the integrator and limp-home term are dropped while stopped; lag, lead and derivative history persist
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         lag_r      <= 16'sh0000;
         sp_prev_r  <= 16'sh0000;
         integ_r    <= 16'sh0000;
         err_prev_r <= 16'sh0000;
         ulh_r      <= 16'sh0000;
         sp_ff_r    <= 16'sh0000;
         u_pid_r    <= 16'sh0000;
         ufc_r      <= 16'sh0000;
         u_r        <= 16'sh0000;
         above_r    <= 1'b0;
      end else if (!run) begin
         integ_r <= 16'sh0000;
         ulh_r   <= 16'sh0000;
      end else if (st_r == ST_CONTROL) begin
         lag_r      <= lagged;
         sp_prev_r  <= sp;
         integ_r    <= integ_nxt;
         err_prev_r <= err;
         ulh_r      <= ulh_nxt;
         sp_ff_r    <= sp_ff;
         u_pid_r    <= upid;
         ufc_r      <= ufc;
         u_r        <= add16(add16(upid, ufc), ulh_nxt);
         above_r    <= above;
      end
   end

   // ************************************************************
   // PWM tick outputs
   // ************************************************************
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PWM_PERIOD <= PW'(PERIOD_TICKS);
         PWM_WIDTH  <= '0;
         PWM_UPDATE <= 1'b0;
      end else begin
         PWM_PERIOD <= PW'(PERIOD_TICKS);
         PWM_UPDATE <= st_r == ST_OUTPUT;
         if (!run) begin
            PWM_WIDTH <= '0;
         end else if (st_r == ST_OUTPUT) begin
            PWM_WIDTH <= (u_r < 0) ? -$signed({1'b0, w_mag})
                                   : $signed({1'b0, w_mag});
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   sequence s_start;
      st_r == ST_IDLE && loop_tick && run;
   endsequence
   sequence s_done;
      ##[1:100] PWM_UPDATE;
   endsequence

   a_loop_update: assert property (
      s_start |-> s_done) else $error("loop update missing");
   a_width_bound: assert property (
      PWM_WIDTH <= $signed({1'b0, PW'(PERIOD_TICKS)}) &&
      PWM_WIDTH >= -$signed({1'b0, PW'(PERIOD_TICKS)}))
      else $error("width above period");
   a_period_fixed: assert property (
      PWM_PERIOD == PW'(PERIOD_TICKS)) else $error("period moved");
   a_width_sign: assert property (
      PWM_UPDATE && run && u_r != 0 |-> (PWM_WIDTH < 0) == (u_r < 0))
      else $error("drive direction wrong");
   a_integ_off: assert property (
      run && st_r == ST_CONTROL && ti == 0 |=> integ_r == 0)
      else $error("integral not disabled");
   a_deriv_off: assert property (
      run && st_r == ST_CONTROL && td == 0
      |=> u_pid_r == add16($past(p_term), integ_r))
      else $error("derivative not disabled");
   a_lh_hold: assert property (
      run && st_r == ST_CONTROL && !near_lh |=> $stable(ulh_r))
      else $error("limp-home term moved outside window");
   a_u_sum: assert property (
      run && st_r == ST_CONTROL
      |=> u_r == add16(add16(u_pid_r, ufc_r), ulh_r))
      else $error("voltage sum wrong");
   a_batt_sel: assert property (
      st_r == ST_MOTOR && div_start_r
      |-> div_den == (batt_en ? batt_r : cfg_r[`IX_BATT_NOM]))
      else $error("battery divisor wrong");
   a_angle_clamp: assert property (
      st_r == ST_FILTER |-> raw_angle_r <= q16_t'(WOT_Q))
      else $error("angle above wide open");
endmodule

// ==== inc/throttle_regs.svh ====
// register indices, field positions, reset values and timing constants
// assumes: included by bare name from the package and the design files
`ifndef THROTTLE_REGS_SVH
`define THROTTLE_REGS_SVH
// ************************************************************
// timing
// ************************************************************
`define CLK_HZ        10000000
`define LOOP_HZ       150
`define PWM_HZ        500
`define TICK_HZ       40000000
`define WOT_ANGLE_DEG 90
`define FRAC_BITS     8
`define DIV_W         34
`define AXI_AW        7
// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define IX_CTRL       5'h00
`define IX_SETPOINT   5'h01
`define IX_SENS_MIN   5'h02
`define IX_SENS_MAX   5'h03
`define IX_LH_ANGLE   5'h04
`define IX_LH_WINDOW  5'h05
`define IX_LH_STEP    5'h06
`define IX_ST_STEP    5'h07
`define IX_LEAD       5'h08
`define IX_LAG        5'h09
`define IX_KP_POS     5'h0A
`define IX_TI_POS     5'h0B
`define IX_TD_POS     5'h0C
`define IX_KP_NEG     5'h0D
`define IX_TI_NEG     5'h0E
`define IX_TD_NEG     5'h0F
`define IX_BATT_NOM   5'h10
`define NUM_CFG       5'h11
`define IX_STATUS     5'h11
`define IX_ANGLE      5'h12
`define IX_SP_FF      5'h13
`define IX_U_PID      5'h14
`define IX_U_TOTAL    5'h15
`define IX_WIDTH      5'h16
`define IX_LAST       5'h16
// ************************************************************
// fields, reset values, responses, filter coefficients (Q2.14)
// ************************************************************
`define CTRL_RUN      0
`define CTRL_BATT     1
`define CTRL_FILT     2
`define RST_SENS_MAX  16'h0FFF
`define RST_BATT_NOM  16'h0C00
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define LP_SHIFT      14
`define LP_B0         16'sh09EC
`define LP_B1         16'sh13D9
`define LP_A1         16'shD84F
`define LP_A2         16'sh0F63
`endif

// ==== inc/throttle_pkg.sv ====
// types and saturating Q8.8 arithmetic shared by the controller files
// assumes: the register header is on the include path
`include "throttle_regs.svh"
package throttle_pkg;
   typedef logic signed [15:0] q16_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ANGLE, ST_FILTER, ST_CONTROL, ST_MOTOR, ST_OUTPUT
   } seq_e;
   function automatic q16_t sat16(input logic signed [31:0] v);
      if (v > 32'sh00007FFF) return 16'sh7FFF;
      if (v < -32'sh00008000) return 16'sh8000;
      return v[15:0];
   endfunction
   function automatic q16_t add16(input q16_t a, input q16_t b);
      return sat16(32'(a) + 32'(b));
   endfunction
   function automatic q16_t sub16(input q16_t a, input q16_t b);
      return sat16(32'(a) - 32'(b));
   endfunction
   function automatic q16_t mulq(input q16_t a, input q16_t b);
      logic signed [31:0] p;
      p = a * b;
      return sat16(p >>> `FRAC_BITS);
   endfunction
   function automatic q16_t abs16(input q16_t v);
      return (v < 0) ? sub16(16'sh0000, v) : v;
   endfunction
endpackage

// ==== hw/ctl_divider.sv ====
// unsigned restoring divider, one quotient bit per clock
// assumes: start is a one-cycle pulse while idle; num/den valid then
`timescale 1ns/10ps
module ctl_divider #(
   parameter int W  = 34,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          start,
   input  wire logic [W-1:0]  num,
   input  wire logic [DW-1:0] den,
   output logic               done,
   output logic [W-1:0]       quot
);
   localparam int CW = $clog2(W + 1);
   logic [DW-1:0] rem_r, den_r;
   logic [W-1:0]  quo_r;
   logic [CW-1:0] cnt_r;
   logic [DW:0]   trial;
   // divide by zero gives all ones, which callers clamp
   assign trial = {rem_r, quo_r[W-1]};
   assign quot  = quo_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rem_r <= '0;
         den_r <= '0;
         quo_r <= '0;
         cnt_r <= '0;
         done  <= 1'b0;
      end else if (start) begin
         rem_r <= '0;
         den_r <= den;
         quo_r <= num;
         cnt_r <= CW'(W);
         done  <= 1'b0;
      end else if (cnt_r != '0) begin
         if (trial >= {1'b0, den_r}) begin
            rem_r <= DW'(trial - {1'b0, den_r});
            quo_r <= {quo_r[W-2:0], 1'b1};
         end else begin
            rem_r <= trial[DW-1:0];
            quo_r <= {quo_r[W-2:0], 1'b0};
         end
         cnt_r <= cnt_r - 1'b1;
         done  <= (cnt_r == CW'(1));
      end else begin
         done <= 1'b0;
      end
   end
endmodule

// ==== hw/ctl_lowpass2.sv ====
// second-order direct-form low-pass, one sample per strobe
// assumes: coefficients in Q2.14 designed for the loop rate
`timescale 1ns/10ps
`include "throttle_regs.svh"
module ctl_lowpass2
   import throttle_pkg::*;
#(
   parameter logic signed [15:0] B0 = `LP_B0,
   parameter logic signed [15:0] B1 = `LP_B1,
   parameter logic signed [15:0] A1 = `LP_A1,
   parameter logic signed [15:0] A2 = `LP_A2
) (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  sample,
   input  wire q16_t  x,
   output q16_t       y
);
   q16_t x1_r, x2_r, y2_r, y_nxt;
   logic signed [34:0] acc;
   always_comb begin
      // widen before multiplying: a 16-bit product would lose the top
      acc = 35'(B0) * 35'(x) + 35'(B1) * 35'(x1_r)
          + 35'(B0) * 35'(x2_r) - 35'(A1) * 35'(y)
          - 35'(A2) * 35'(y2_r);
      y_nxt = sat16(32'(acc >>> `LP_SHIFT));
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         x1_r <= 16'sh0000;
         x2_r <= 16'sh0000;
         y2_r <= 16'sh0000;
         y    <= 16'sh0000;
      end else if (sample) begin
         x1_r <= x;
         x2_r <= x1_r;
         y2_r <= y;
         y    <= y_nxt;
      end
   end
endmodule

// ==== test/throttle_plant.sv ====
// throttle body model: bridge, DC motor and plate position sensor
// assumes: width is the signed pulse width, update its strobe
`timescale 1ns/10ps
module throttle_plant (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               hold,
   input  wire logic [15:0]        raw_set,
   input  wire logic signed [17:0] width,
   input  wire logic               update,
   output logic [15:0]             raw
);
   // slow plate, one step per update; end stops clamp the travel
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         raw <= 16'h0000;
      else if (hold)
         raw <= raw_set;
      else if (update && width < 0 && raw >= 16'h0040)
         raw <= raw - 16'h0040;
      else if (update && width > 0 && raw <= 16'h0FBF)
         raw <= raw + 16'h0040;
   end
endmodule

// ==== test/throttle_position_controller_tb.sv ====
// self-checking bench: AXI4-Lite registers and loop outputs
// assumes: plant model compiled first, loop shortened to 200 cycles
`timescale 1ns/10ps
module throttle_position_controller_tb;
   import throttle_pkg::*;
   logic               CLOCK = 0, RESET = 1, hold = 1;
   logic               AWVALID = 0, WVALID = 0, BREADY = 0;
   logic               ARVALID = 0, RREADY = 0;
   logic               AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic               PWM_UPDATE;
   logic [6:0]         AWADDR = 0, ARADDR = 0;
   logic [31:0]        WDATA = 0, RDATA;
   logic [3:0]         WSTRB = 4'hF;
   logic [1:0]         BRESP, RRESP;
   logic [15:0]        SENSOR_RAW, raw_set = 0;
   q16_t               BATTERY_VOLTS = 16'h0C00;
   logic [16:0]        PWM_PERIOD;
   logic signed [17:0] PWM_WIDTH;
   int                 miscompares = 0, comparisons = 0;
   logic [33:0]        exp_r[$];
   logic [1:0]         exp_b[$];
   logic signed [31:0] exp_w[$];

   always #50 CLOCK = ~CLOCK;
   throttle_position_controller #(.LOOP_COUNT(200))
      i_throttle_position_controller (.*);
   throttle_plant i_throttle_plant (.clk(CLOCK), .rst(RESET),
      .hold(hold), .raw_set(raw_set), .width(PWM_WIDTH),
      .update(PWM_UPDATE), .raw(SENSOR_RAW));

   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [4:0] ix, input logic [15:0] d,
                     input logic [1:0] rsp);
      exp_b.push_back(rsp);
      @(posedge CLOCK);
      AWADDR <= {ix, 2'b00};
      WDATA <= {16'h0000, d};
      AWVALID <= 1;
      WVALID <= 1;
      BREADY <= 1;
      // each channel is released at the edge that takes it
      fork
         begin
            do @(posedge CLOCK); while (AWREADY !== 1'b1);
            AWVALID <= 0;
         end
         begin
            do @(posedge CLOCK); while (WREADY !== 1'b1);
            WVALID <= 0;
         end
      join
      do @(posedge CLOCK); while (BVALID !== 1'b1);
      BREADY <= 0;
   endtask
   task automatic rd(input logic [4:0] ix, input logic [33:0] want);
      exp_r.push_back(want);
      @(posedge CLOCK);
      ARADDR <= {ix, 2'b00};
      ARVALID <= 1;
      RREADY <= 1;
      do @(posedge CLOCK); while (ARREADY !== 1'b1);
      ARVALID <= 0;
      do @(posedge CLOCK); while (RVALID !== 1'b1);
      RREADY <= 0;
   endtask
   task automatic wait_upd;
      do @(posedge CLOCK); while (PWM_UPDATE !== 1'b1);
   endtask
   // two updates skipped: one may have started before the new setup
   task automatic expect_w(input logic signed [31:0] w, input logic rnd);
      repeat (2) wait_upd();
      repeat (2) begin
         if (rnd)
            BATTERY_VOLTS <= 16'($urandom_range(32'h7FFF, 32'h0400));
         @(negedge CLOCK);
         exp_w.push_back(w);
         wait_upd();
      end
   endtask

   always @(posedge CLOCK) begin
      if (RVALID === 1'b1 && RREADY && exp_r.size() > 0)
         check({RRESP, RDATA}, exp_r.pop_front());
      if (BVALID === 1'b1 && BREADY && exp_b.size() > 0)
         check(BRESP, exp_b.pop_front());
      if (PWM_UPDATE === 1'b1) begin
         check(PWM_WIDTH <= 80000 && PWM_WIDTH >= -80000, 1);
         if (exp_w.size() > 0)
            check(PWM_WIDTH, exp_w.pop_front());
      end
   end

   initial begin
      void'($urandom(32'h148A));
      repeat (20) @(posedge CLOCK);
      RESET <= 0;
      check(PWM_PERIOD, 80000);
      check(PWM_WIDTH, 0);
      rd(5'h03, {2'h0, 32'h0FFF});
      rd(5'h10, {2'h0, 32'h0C00});
      rd(5'h17, {2'h2, 32'h0});
      wr(5'h11, 16'h1234, 2'h2);
      wr(5'h0D, 16'h0004, 2'h0);
      wr(5'h0A, 16'h0008, 2'h0);
      wr(5'h01, 16'h2D00, 2'h0);
      wr(5'h00, 16'h0001, 2'h0);
      expect_w(180 * 80000 / 3072, 1);
      BATTERY_VOLTS <= 16'h1800;
      wr(5'h00, 16'h0003, 2'h0);
      expect_w(180 * 80000 / 6144, 0);
      wr(5'h00, 16'h0001, 2'h0);
      raw_set <= 16'h0FFF;
      wr(5'h01, 16'h0000, 2'h0);
      expect_w(-(720 * 80000 / 3072), 0);
      wr(5'h06, 16'h0100, 2'h0);
      expect_w(-(976 * 80000 / 3072), 0);
      wr(5'h07, 16'h0100, 2'h0);
      wr(5'h01, 16'h2D00, 2'h0);
      expect_w(-(872 * 80000 / 3072), 0);
      rd(5'h12, {2'h0, 32'h5A00});
      wr(5'h0A, 16'h0100, 2'h0);
      expect_w(-80000, 0);
      // filter settles a steady 90 degree input three LSBs low
      wr(5'h00, 16'h0005, 2'h0);
      repeat (8) wait_upd();
      rd(5'h12, {2'h0, 32'h59FD});
      hold <= 0;
      repeat (4) wait_upd();
      wr(5'h00, 16'h0000, 2'h0);
      repeat (3) @(posedge CLOCK);
      check(PWM_WIDTH, 0);
      tally_and_finish();
   end
   initial begin
      #(30000 * 100);
      miscompares++;
      tally_and_finish();
   end
endmodule
